/* src/remote_address_data_decoder.v */
// decoder stage: serial code word in, address check, parallel data out
// assumes the received line is already a clean logic level in the
// system clock domain and that the sender keeps it low between words
`timescale 1ns/1ps
`include "rx_decoder_map.vh"

module remote_address_data_decoder #(
  parameter IDLE_TICKS = `IDLE_TICKS,
  parameter GAP_TICKS  = 64,
  parameter OSC_DIV    = `OSC_DIV
) (
  // clock and reset
  input  wire       i_sys_clk,
  input  wire       i_nrst,
  // receiver side
  input  wire       i_rx_data,
  input  wire       i_power_down_n,
  // local address pins
  input  wire [9:0] i_local_address_inputs,
  output reg        o_address_bias_up,
  // decoded results
  output reg  [7:0] o_decoded_outputs,
  output reg        o_valid_flag,
  output reg        o_rx_data_raw
);

  // ==========================================================
  // states of the acceptance sequence
  localparam [1:0] ST_IDLE  = 2'b00;
  localparam [1:0] ST_ONCE  = 2'b01;
  localparam [1:0] ST_VALID = 2'b10;
  // last divider count before an oscillator tick
  localparam [11:0] DIV_END = OSC_DIV[11:0] - 12'h001;

  // ==========================================================
  // declarations
  reg  [1:0]  state_q;
  reg  [1:0]  state_d;
  reg         osc_run_q;
  reg  [11:0] div_q;
  reg         tick_q;
  reg  [11:0] idle_q;
  reg         line_q;
  reg  [35:0] word_q;
  reg  [5:0]  sub_cnt_q;
  reg         bad_q;
  reg         word_done_q;
  reg  [7:0]  data_d;
  reg         valid_d;
  wire        sub_valid;
  wire        sub_bit;
  wire        gap;
  wire        bias_up;
  wire [19:0] local_sym;
  wire        addr_match;
  wire        data_ok;
  wire [7:0]  word_data;

  // ==========================================================
  // helpers
  // pair of sub-bits forming symbol i, first sub-bit in the msb
  function [1:0] sym_at;
    input [35:0] w;
    input [4:0]  i;
    begin
      sym_at = {w[{i, 1'b0}], w[{i, 1'b0} + 6'd1]};
    end
  endfunction

  // ==========================================================
  // address pin sensing
  ternary_sense #(
    .N      (`ADDR_SYMS),
    .SETTLE (`SETTLE_CYCLES)
  ) u_sense (
    .i_sys_clk (i_sys_clk),
    .i_nrst    (i_nrst),
    .i_pins    (i_local_address_inputs),
    .o_bias_up (bias_up),
    .o_sym     (local_sym)
  );

  // bias control leaves through a flop like every other output
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst)
      o_address_bias_up <= 1'b1;
    else
      o_address_bias_up <= bias_up;
  end

  // ==========================================================
  // raw data pin, ahead of the decoder and blind to the address
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rx_data_raw <= 1'b0;
      line_q        <= 1'b0;
    end else begin
      o_rx_data_raw <= i_rx_data & i_power_down_n;
      line_q        <= i_rx_data & i_power_down_n;
    end
  end

  // ==========================================================
  // decoder oscillator: started by a high line, stopped after a long
  // quiet spell; a line stuck high keeps it running, hence the sender
  // must idle low
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      osc_run_q <= 1'b0;
      div_q     <= 12'h000;
      tick_q    <= 1'b0;
      idle_q    <= 12'h000;
    end else begin
      tick_q <= 1'b0;
      if (!i_power_down_n) begin
        osc_run_q <= 1'b0;
        div_q     <= 12'h000;
        idle_q    <= 12'h000;
      end else if (!osc_run_q) begin
        if (line_q) begin
          osc_run_q <= 1'b1;
          idle_q    <= 12'h000;
          // tick at once so the waking edge is measured, not missed
          div_q     <= DIV_END;
        end
      end else begin
        if (div_q == DIV_END) begin
          div_q  <= 12'h000;
          tick_q <= 1'b1;
          if (line_q)
            idle_q <= 12'h000;
          else if (idle_q == IDLE_TICKS[11:0]) begin
            osc_run_q <= 1'b0;
            idle_q    <= 12'h000;
          end else
            idle_q <= idle_q + 12'h001;
        end else begin
          div_q <= div_q + 12'h001;
        end
      end
    end
  end

  // ==========================================================
  // sub-bit extraction on oscillator ticks
  pulse_meter #(
    .W   (12),
    .GAP (GAP_TICKS)
  ) u_meter (
    .i_sys_clk   (i_sys_clk),
    .i_nrst      (i_nrst),
    .i_tick      (tick_q),
    .i_line      (line_q),
    .o_sub_valid (sub_valid),
    .o_sub_bit   (sub_bit),
    .o_gap       (gap)
  );

  // ==========================================================
  // word assembly; a word with the wrong sub-bit count is dropped
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      word_q      <= 36'h0_0000_0000;
      sub_cnt_q   <= 6'h00;
      bad_q       <= 1'b0;
      word_done_q <= 1'b0;
    end else begin
      word_done_q <= 1'b0;
      if (!i_power_down_n || !osc_run_q) begin
        sub_cnt_q <= 6'h00;
        bad_q     <= 1'b0;
      end else if (sub_valid) begin
        if (sub_cnt_q < `WORD_SUBS)
          word_q[sub_cnt_q] <= sub_bit;
        else
          bad_q <= 1'b1;
        if (gap) begin
          word_done_q <= !bad_q && (sub_cnt_q == (`WORD_SUBS - 1));
          sub_cnt_q   <= 6'h00;
          bad_q       <= 1'b0;
        end else begin
          sub_cnt_q <= sub_cnt_q + 6'h01;
        end
      end
    end
  end

  // ==========================================================
  // field checks: every symbol compared in full, float included
  genvar g;
  wire [9:0] sym_eq;
  wire [7:0] data_pair_ok;
  generate
    for (g = 0; g < `ADDR_SYMS; g = g + 1) begin : g_addr
      assign sym_eq[g] = (sym_at(word_q, g) == local_sym[2*g +: 2]);
    end
    for (g = 0; g < `DATA_BITS; g = g + 1) begin : g_data
      wire [1:0] p = sym_at(word_q, `ADDR_SYMS + g);
      assign data_pair_ok[g] = (p == `SYM_LOW) || (p == `SYM_HIGH);
      assign word_data[g]    = p[0];
    end
  endgenerate

  assign addr_match = &sym_eq;
  assign data_ok    = &data_pair_ok;

  // ==========================================================
  // acceptance sequence
  always @* begin
    state_d = state_q;
    data_d  = o_decoded_outputs;
    valid_d = o_valid_flag;
    case (state_q)
      ST_IDLE: begin
        if (word_done_q && addr_match && data_ok)
          state_d = ST_ONCE;
      end
      ST_ONCE: begin
        if (word_done_q) begin
          if (addr_match && data_ok) begin
            state_d = ST_VALID;
            data_d  = word_data;
            valid_d = 1'b1;
          end else begin
            state_d = ST_IDLE;
          end
        end
      end
      ST_VALID: begin
        if (word_done_q) begin
          if (addr_match && data_ok) begin
            data_d = word_data;
          end else begin
            state_d = ST_IDLE;
            data_d  = 8'h00;
            valid_d = 1'b0;
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
        data_d  = 8'h00;
        valid_d = 1'b0;
      end
    endcase
    // loss of signal or power-down ends any reception
    if (!osc_run_q || !i_power_down_n) begin
      state_d = ST_IDLE;
      data_d  = 8'h00;
      valid_d = 1'b0;
    end
  end

  // outputs straight from flops
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q           <= ST_IDLE;
      o_decoded_outputs <= 8'h00;
      o_valid_flag      <= 1'b0;
    end else begin
      state_q           <= state_d;
      o_decoded_outputs <= data_d;
      o_valid_flag      <= valid_d;
    end
  end

endmodule // remote_address_data_decoder

/* src/rx_decoder_map.vh */
// named constants for the remote address/data decoder
// assumes a 125 MHz system clock and a slow pulse-width coded serial link
//
// Overview of operation
// - first 10 symbols address, last 8 data
// - activity on received line starts decoder oscillator
// - oscillator stopped in standby, started by high
// - address must match on two consecutive words
// - second and later matching words copy 8 data bits out
// - valid flag high only during valid reception
// - valid ends on mismatch or signal loss
// - data outputs momentary, reset when valid ends
// - ten tri-state address inputs, 59049 settings
// - every address symbol must match exactly, float included
// - mismatching word leaves idle outputs untouched
// - power-down low blocks all reception
// - raw received stream copied to its own pin
// - raw output independent of address match
`ifndef RX_DECODER_MAP_VH
`define RX_DECODER_MAP_VH

// ==========================================================
// timing
`define SYS_CLK_HZ        125000000
`define OSC_FREQ_HZ       70000
`define OSC_DIV           (`SYS_CLK_HZ / `OSC_FREQ_HZ)
`define IDLE_TIME_US      10000
`define IDLE_TICKS        ((`IDLE_TIME_US * (`OSC_FREQ_HZ / 1000)) / 1000)
`define SETTLE_CYCLES     16

// ==========================================================
// code word layout, in sub-bits (two sub-bits per symbol)
`define ADDR_SYMS         10
`define DATA_BITS         8
`define WORD_SUBS         36
`define DATA_SUB_BASE     20

// ==========================================================
// symbol codes: {first sub-bit, second sub-bit}
`define SYM_LOW           2'b00
`define SYM_HIGH          2'b11
`define SYM_FLOAT         2'b01

`endif

/* src/ternary_sense.v */
// ternary sensing of the tri-state local address pins
// assumes each pin has a weak bias resistor switched by o_bias_up
`timescale 1ns/1ps
`include "rx_decoder_map.vh"

module ternary_sense #(
  parameter N      = `ADDR_SYMS,
  parameter SETTLE = `SETTLE_CYCLES
) (
  // clock and reset
  input  wire           i_sys_clk,
  input  wire           i_nrst,
  // address pins
  input  wire [N-1:0]   i_pins,
  output reg            o_bias_up,
  // sensed symbols, two bits per pin
  output reg  [2*N-1:0] o_sym
);

  reg [7:0]   settle_q;
  reg [N-1:0] lvl_up_q;
  integer     k;

  // bias alternates up and down; a pin that follows the bias is floating
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      settle_q  <= 8'h00;
      o_bias_up <= 1'b1;
      lvl_up_q  <= {N{1'b0}};
      o_sym     <= {2*N{1'b0}};
    end else if (settle_q == SETTLE[7:0]) begin
      settle_q  <= 8'h00;
      o_bias_up <= ~o_bias_up;
      if (o_bias_up) begin
        lvl_up_q <= i_pins;
      end else begin
        for (k = 0; k < N; k = k + 1) begin
          if (lvl_up_q[k] && !i_pins[k])
            o_sym[2*k +: 2] <= `SYM_FLOAT;
          else if (i_pins[k])
            o_sym[2*k +: 2] <= `SYM_HIGH;
          else
            o_sym[2*k +: 2] <= `SYM_LOW;
        end
      end
    end else begin
      settle_q <= settle_q + 8'h01;
    end
  end

endmodule // ternary_sense

/* src/pulse_meter.v */
// pulse-width classification of the received line at oscillator rate
// assumes i_tick is a one-cycle strobe from the decoder oscillator
`timescale 1ns/1ps
`include "rx_decoder_map.vh"

module pulse_meter #(
  parameter W   = 12,
  parameter GAP = 64
) (
  // clock and reset
  input  wire i_sys_clk,
  input  wire i_nrst,
  // sampled line
  input  wire i_tick,
  input  wire i_line,
  // results
  output reg  o_sub_valid,
  output reg  o_sub_bit,
  output reg  o_gap
);

  reg [W-1:0] hi_q;
  reg [W-1:0] tot_q;
  reg [W-1:0] last_tot_q;
  reg         prev_q;
  reg         in_pulse_q;

  // long high share of a period means one, short means zero
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      hi_q        <= {W{1'b0}};
      tot_q       <= {W{1'b0}};
      last_tot_q  <= {W{1'b0}};
      prev_q      <= 1'b0;
      in_pulse_q  <= 1'b0;
      o_sub_valid <= 1'b0;
      o_sub_bit   <= 1'b0;
      o_gap       <= 1'b0;
    end else begin
      o_sub_valid <= 1'b0;
      o_gap       <= 1'b0;
      if (i_tick) begin
        prev_q <= i_line;
        if (i_line && !prev_q) begin
          if (in_pulse_q) begin
            o_sub_valid <= 1'b1;
            o_sub_bit   <= ({hi_q, 1'b0} > {1'b0, tot_q});
            last_tot_q  <= tot_q;
          end
          in_pulse_q <= 1'b1;
          hi_q       <= {{(W-1){1'b0}}, 1'b1};
          tot_q      <= {{(W-1){1'b0}}, 1'b1};
        end else if (in_pulse_q) begin
          if (i_line)
            hi_q <= hi_q + 1'b1;
          tot_q <= tot_q + 1'b1;
          // last period has no closing edge: judge against previous period
          if (!i_line && (tot_q - hi_q) > GAP[W-1:0]) begin
            o_sub_valid <= 1'b1;
            o_sub_bit   <= ({hi_q, 1'b0} > {1'b0, last_tot_q});
            o_gap       <= 1'b1;
            in_pulse_q  <= 1'b0;
          end
        end
      end
    end
  end

endmodule // pulse_meter

/* tb/decoder_checker_sva.sv */
// checker: port-level timing of the address/data decoder
// assumes it is bound to the decoder top and sees only its ports
`timescale 1ns/1ps
`include "rx_decoder_map.vh"
// ==========================================================
// decoder checker
module decoder_checker #(
  parameter IDLE_TICKS = 700,
  parameter GAP_TICKS  = 64,
  parameter OSC_DIV    = `OSC_DIV
) (
  // clock and reset
  input wire       i_sys_clk,
  input wire       i_nrst,
  // inputs
  input wire       i_rx_data,
  input wire       i_power_down_n,
  input wire [9:0] i_local_address_inputs,
  // outputs
  input wire       o_address_bias_up,
  input wire [7:0] o_decoded_outputs,
  input wire       o_valid_flag,
  input wire       o_rx_data_raw
);
  localparam int OD = OSC_DIV;
  logic [23:0] low_q;

  // cycles since the line was last high; saturates so long idles stay large
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst)
      low_q <= '0;
    else if (i_rx_data)
      low_q <= '0;
    else if (low_q != '1)
      low_q <= low_q + 1'b1;
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);

  AST_RAW_COPY: assert property (1'b1 |=> o_rx_data_raw == $past(i_rx_data && i_power_down_n))
    else $error("raw output is not the gated line one clock late");
  AST_PDN_QUIET: assert property (!i_power_down_n ##1 !i_power_down_n |-> !o_valid_flag && o_decoded_outputs == 8'h00)
    else $error("outputs active during power down");
  AST_DATA_MOMENTARY: assert property (!o_valid_flag |-> o_decoded_outputs == 8'h00)
    else $error("data outputs set without valid");
  AST_RISE_AFTER_GAP: assert property ($rose(o_valid_flag) |-> low_q >= GAP_TICKS * OD && low_q <= (GAP_TICKS + 5) * OD)
    else $error("valid rose away from a word end");
  AST_IDLE_DROP: assert property (o_valid_flag |-> low_q <= (IDLE_TICKS + 3) * OD)
    else $error("valid outlived the idle timeout");
  AST_FALL_AT_END: assert property ($fell(o_valid_flag) && i_power_down_n |-> low_q >= GAP_TICKS * OD)
    else $error("valid fell inside a word");
  AST_DATA_HOLD: assert property (o_valid_flag && $changed(o_decoded_outputs) |-> low_q >= GAP_TICKS * OD)
    else $error("data changed inside a word");
  AST_BIAS_PHASE: assert property ($changed(o_address_bias_up) |=> $stable(o_address_bias_up) [*8])
    else $error("bias phase too short");

  // main scenarios reached
  COV_VALID: cover property ($rose(o_valid_flag));
  COV_DROP: cover property ($fell(o_valid_flag) && i_power_down_n);
  COV_PDN: cover property (!i_power_down_n && i_rx_data);
endmodule // decoder_checker

bind remote_address_data_decoder decoder_checker #(
  .IDLE_TICKS(IDLE_TICKS),
  .GAP_TICKS (GAP_TICKS),
  .OSC_DIV   (OSC_DIV)
) u_decoder_checker (
  .i_sys_clk             (i_sys_clk),
  .i_nrst                (i_nrst),
  .i_rx_data             (i_rx_data),
  .i_power_down_n        (i_power_down_n),
  .i_local_address_inputs(i_local_address_inputs),
  .o_address_bias_up     (o_address_bias_up),
  .o_decoded_outputs     (o_decoded_outputs),
  .o_valid_flag          (o_valid_flag),
  .o_rx_data_raw         (o_rx_data_raw)
);

/* tb/encoder_model.sv */
// remote encoder model driving the received-data line
// assumes the oscillator rate of the shared decoder header
`timescale 1ns/1ps
`include "rx_decoder_map.vh"
// ==========================================================
// encoder model
module encoder_model #(
  parameter int OSC_DIV = `OSC_DIV
) (
  // clock
  input  wire  i_sys_clk,
  // line to the decoder
  output logic o_line
);
  // idle low so the decoder oscillator stays stopped
  initial o_line = 1'b0;

  // wait n oscillator periods, stepping just off the edge
  task automatic units(input int n);
    repeat (n * OSC_DIV) @(posedge i_sys_clk);
    #1;
  endtask

  // hold a level for n periods
  task automatic hold(input logic v, input int n);
    o_line = v;
    units(n);
  endtask

  // one sub-bit: wide high is a one; always ends low
  task automatic sub(input logic b);
    hold(1'b1, b ? 2 : 1);
    hold(1'b0, b ? 1 : 2);
  endtask

  // ten address symbols, then eight data symbols, first sub-bit msb
  task automatic send_word(input logic [19:0] a, input logic [7:0] d);
    for (int s = 0; s < 18; s++) begin
      sub(s < 10 ? a[2*s+1] : d[s-10]);
      sub(s < 10 ? a[2*s] : d[s-10]);
    end
  endtask
endmodule // encoder_model

/* tb/testbench.sv */
// self-checking bench for the address/data decoder
// assumes the encoder model and the bound checker are compiled with it
`timescale 1ns/1ps
// ==========================================================
// bench top
module testbench;
  localparam logic [19:0] LA = 20'h7_1c34; // local: float, high, low pins
  localparam logic [19:0] MA = 20'h7_1c35; // pin 0 sent floating
  localparam logic [19:0] MB = 20'h7_1c3c; // pin 1 sent high
  localparam logic [19:0] RA [7] = '{LA, LA, LA, MA, LA, MB, LA};
  localparam logic [7:0]  RD [7] = '{8'ha5, 8'ha5, 8'h3c, 8'h3c, 8'h5a, 8'h5a, 8'h5a};
  localparam logic [7:0]  XD [7] = '{8'h00, 8'ha5, 8'h3c, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [6:0]  XV     = 7'h06;
  logic       i_sys_clk      = 1'b0;
  logic       i_nrst         = 1'b0;
  logic       i_power_down_n = 1'b1;
  logic [9:0] pins;
  logic [19:0] la            = LA;
  wire        rx;
  wire        bias;
  wire        valid;
  wire        raw;
  wire  [7:0] dout;
  int         n_mismatch     = 0;
  int         comparisons    = 0;

  // 125 MHz clock
  always #4 i_sys_clk = ~i_sys_clk;

  // floating pins follow the weak bias, driven pins keep their level
  always_comb for (int k = 0; k < 10; k++) pins[k] = (la[2*k+:2] == 2'b01) ? bias : la[2*k+1];

  // short oscillator period keeps the run well under the cycle budget
  remote_address_data_decoder #(.IDLE_TICKS(40), .GAP_TICKS(8), .OSC_DIV(16)) u_remote_address_data_decoder (
    .i_sys_clk             (i_sys_clk),
    .i_nrst                (i_nrst),
    .i_rx_data             (rx),
    .i_power_down_n        (i_power_down_n),
    .i_local_address_inputs(pins),
    .o_address_bias_up     (bias),
    .o_decoded_outputs     (dout),
    .o_valid_flag          (valid),
    .o_rx_data_raw         (raw)
  );

  encoder_model #(.OSC_DIV(16)) u_encoder_model (
    .i_sys_clk(i_sys_clk),
    .o_line   (rx)
  );

  // compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (n_mismatch == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // one word, then enough low line for the decoder to close it
  task automatic word(input logic [19:0] a, input logic [7:0] d);
    u_encoder_model.send_word(a, d);
    u_encoder_model.units(12);
  endtask

  // main sequence
  initial begin
    repeat (8) @(posedge i_sys_clk);
    #1;
    chk({valid, raw, bias, 5'h00}, 8'h20);
    chk(dout, 8'h00);
    i_nrst = 1'b1;
    repeat (64) @(posedge i_sys_clk);
    #1;
    for (int r = 0; r < 7; r++) begin
      word(RA[r], RD[r]);
      chk({7'h00, valid}, {7'h00, XV[r]});
      chk(dout, XD[r]);
      u_encoder_model.units(2);
    end
    // second match after the restart uses the second word's data
    word(LA, 8'h81);
    chk({7'h00, valid}, 8'h01);
    chk(dout, 8'h81);
    // power down with the line high: nothing passes
    i_power_down_n = 1'b0;
    u_encoder_model.hold(1'b1, 1);
    chk({6'h00, valid, raw}, 8'h00);
    chk(dout, 8'h00);
    i_power_down_n = 1'b1;
    repeat (2) @(posedge i_sys_clk);
    #1;
    chk({7'h00, raw}, 8'h01);
    u_encoder_model.hold(1'b0, 20);
    // valid, then silence past the idle limit
    word(LA, 8'hc3);
    u_encoder_model.units(2);
    word(LA, 8'hc3);
    chk({7'h00, valid}, 8'h01);
    chk(dout, 8'hc3);
    u_encoder_model.units(32);
    chk({7'h00, valid}, 8'h00);
    chk(dout, 8'h00);
    // new local address with pin 0 floating: float must match float
    la = MA;
    repeat (64) @(posedge i_sys_clk);
    #1;
    word(MA, 8'h69);
    u_encoder_model.units(2);
    word(MA, 8'h69);
    chk({7'h00, valid}, 8'h01);
    chk(dout, 8'h69);
    tally_and_finish();
  end

  // watchdog: the run needs about 25 thousand clocks
  initial begin
    repeat (32'h0000_ea60) @(posedge i_sys_clk);
    n_mismatch++;
    tally_and_finish();
  end
endmodule // testbench
